// [tccd_top.sv]
// cc detection control: i2c register slave, switch matrix, comparator status, drp toggle
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - power-up reset loads every register with its default value.
// - chip soft reset bit performs a reset equal to power-up.
// - protocol reset bit resets all power delivery logic.
// - switch bits 4 and 5 connect cable supply to line 1 and 2.
// - switch bits 2 and 3 route line 1 and 2 to sensing.
// - transmit select bits 0 and 1 pick the line carrying outgoing messages.
// - switch bits 6 and 7 enable source pull-ups on line 1 and 2.
// - switch bits 0 and 1 enable sink pull-downs on line 1 and 2.
// - coarse level change raises its event; level shown in status bits 1:0.
// - dac threshold from measure bits 5:0; result bit 5; change raises event.
// - measure bit 6 applies the dac comparator to the supply rail.
// - supply valid comparator reported in status; change raises its event.
// - detection control bit 0 runs automatic detection driving pull and sense switches itself.
// - detection bits 2:1 select role; 2'b10 is sink only.
// - toggle completion raises done event and encodes outcome in 0x3d bits 5:3.
// - sink meaning of coarse level, dac compare and supply valid.
// - source current field 0x06 bits 3:2 drives the advertised current.
// - as source, dac compare 0 means sink attached, 1 detached.
// - dual role alternates source and sink with software-set timing.
module tccd_top (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    input wire logic [1:0] COARSE_LEVEL_IN,
    input wire logic DAC_COMPARE_IN,
    input wire logic SUPPLY_VALID_IN,
    input wire logic [1:0] LINE1_TERM_IN,
    input wire logic [1:0] LINE2_TERM_IN,
    output logic CABLE_SUPPLY_LINE1_OUT,
    output logic CABLE_SUPPLY_LINE2_OUT,
    output logic SENSE_LINE1_OUT,
    output logic SENSE_LINE2_OUT,
    output logic TRANSMIT_ON_LINE1_OUT,
    output logic TRANSMIT_ON_LINE2_OUT,
    output logic SOURCE_PULLUP_LINE1_OUT,
    output logic SOURCE_PULLUP_LINE2_OUT,
    output logic SINK_PULLDOWN_LINE1_OUT,
    output logic SINK_PULLDOWN_LINE2_OUT,
    output logic [5:0] DAC_THRESHOLD_CODE_OUT,
    output logic DAC_ON_SUPPLY_RAIL_OUT,
    output logic [1:0] ADVERTISED_SOURCE_CURRENT_OUT,
    output logic PROTOCOL_LOGIC_RESET_OUT
);
    logic [1:0] scl_sync_ff, sda_sync_ff;
    logic scl_q_ff, sda_q_ff;
    logic [5:0] ana_meta_ff, ana_ff, ana_q_ff;
    logic [3:0] term_meta_ff, term_ff;
    logic soft_rst_ff;
    logic rst_all;
    logic [7:0] switch_ff, txsel_ff, measure_ff, portctl_ff, detctl_ff, events_ff;
    tccd_pkg::tccd_i2c_t i2c_st_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff, ptr_ff, rd_byte_ff;
    logic ack_ph_ff, rd_mode_ff, oe_ff;
    logic wr_stb_ff;
    logic [7:0] wr_addr_ff, wr_data_ff;
    tccd_pkg::tccd_tog_t tog_st_ff;
    logic [2:0] tog_code_ff;
    logic [7:0] tick_cnt_ff, phase_cnt_ff;
    logic tog_done_ev;
    logic scl_rise, scl_fall, i2c_start, i2c_stop;
    logic auto_en;
    logic [1:0] mode;
    logic [7:0] rd_now;

    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] sw,
        input logic [7:0] tx, input logic [7:0] ms, input logic [7:0] pc,
        input logic [7:0] dc, input logic [2:0] tc, input logic [5:0] an,
        input logic [7:0] ev);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            tccd_pkg::OFS_SWITCH: d = sw;
            tccd_pkg::OFS_TXSEL: d = tx;
            tccd_pkg::OFS_MEASURE: d = ms;
            tccd_pkg::OFS_PORTCTL: d = pc;
            tccd_pkg::OFS_DETCTL: d = dc;
            tccd_pkg::OFS_TOGSTAT: d = {2'h0, tc, 3'h0};
            tccd_pkg::OFS_LVLSTAT: d = {an[3], 1'b0, an[2], 3'h0, an[1:0]};
            tccd_pkg::OFS_EVENTS: d = ev;
            default: d = 8'h00;
        endcase
        return d;
    endfunction : reg_read

    // pins and analog comparator levels are asynchronous: two flops before use
    always_ff @(posedge CLK_IN) begin
        scl_sync_ff <= {scl_sync_ff[0], SCL_IN};
        sda_sync_ff <= {sda_sync_ff[0], SDA_IN};
        scl_q_ff <= scl_sync_ff[1];
        sda_q_ff <= sda_sync_ff[1];
        ana_meta_ff <= {SUPPLY_VALID_IN, DAC_COMPARE_IN, 2'h0, COARSE_LEVEL_IN};
        ana_ff <= {ana_meta_ff[5:4], ana_meta_ff[5], ana_meta_ff[4], ana_meta_ff[1:0]};
        term_meta_ff <= {LINE2_TERM_IN, LINE1_TERM_IN};
        term_ff <= term_meta_ff;
    end

    assign scl_rise = scl_sync_ff[1] & ~scl_q_ff;
    assign scl_fall = ~scl_sync_ff[1] & scl_q_ff;
    assign i2c_start = scl_sync_ff[1] & scl_q_ff & sda_q_ff & ~sda_sync_ff[1];
    assign i2c_stop = scl_sync_ff[1] & scl_q_ff & ~sda_q_ff & sda_sync_ff[1];
    assign rst_all = ~RST_N_IN | soft_rst_ff;
    assign auto_en = detctl_ff[0];
    assign mode = detctl_ff[2:1];
    // a function result cannot be bit-selected, so the read byte gets its own net
    assign rd_now = reg_read(ptr_ff, switch_ff, txsel_ff, measure_ff, portctl_ff, detctl_ff,
        tog_code_ff, ana_q_ff, events_ff);

    // only the pin reset clears the soft reset pulse, so it lasts exactly one cycle
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            soft_rst_ff <= 1'b0;
            PROTOCOL_LOGIC_RESET_OUT <= 1'b0;
        end else begin
            soft_rst_ff <= wr_stb_ff & (wr_addr_ff == tccd_pkg::OFS_RESET)
                & wr_data_ff[tccd_pkg::RST_CHIP];
            PROTOCOL_LOGIC_RESET_OUT <= soft_rst_ff | (wr_stb_ff
                & (wr_addr_ff == tccd_pkg::OFS_RESET) & wr_data_ff[tccd_pkg::RST_PROTO]);
        end
    end

    // i2c slave: 7-bit address, pointer byte, auto-incrementing data
    always_ff @(posedge CLK_IN) begin
        if (rst_all) begin
            i2c_st_ff <= tccd_pkg::IS_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rd_byte_ff <= 8'h00;
            ack_ph_ff <= 1'b0;
            rd_mode_ff <= 1'b0;
            oe_ff <= 1'b0;
            wr_stb_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
        end else begin
            wr_stb_ff <= 1'b0;
            if (i2c_start) begin
                i2c_st_ff <= tccd_pkg::IS_DEV;
                bit_cnt_ff <= 4'h0;
                ack_ph_ff <= 1'b0;
                oe_ff <= 1'b0;
            end else if (i2c_stop) begin
                i2c_st_ff <= tccd_pkg::IS_IDLE;
                oe_ff <= 1'b0;
            end else if (scl_rise && i2c_st_ff != tccd_pkg::IS_IDLE) begin
                if (!ack_ph_ff) begin
                    shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end else if (i2c_st_ff == tccd_pkg::IS_RDATA && sda_sync_ff[1]) begin
                    i2c_st_ff <= tccd_pkg::IS_IDLE; // master nack ends the read
                end
            end else if (scl_fall && i2c_st_ff != tccd_pkg::IS_IDLE) begin
                if (ack_ph_ff) begin
                    ack_ph_ff <= 1'b0;
                    bit_cnt_ff <= 4'h0;
                    oe_ff <= 1'b0;
                    if (i2c_st_ff == tccd_pkg::IS_DEV) begin
                        i2c_st_ff <= rd_mode_ff ? tccd_pkg::IS_RDATA : tccd_pkg::IS_PTR;
                    end
                    if (rd_mode_ff) begin
                        rd_byte_ff <= rd_now;
                        oe_ff <= ~rd_now[7];
                    end
                end else if (bit_cnt_ff == 4'h8) begin
                    ack_ph_ff <= 1'b1;
                    unique case (i2c_st_ff)
                        tccd_pkg::IS_DEV: begin
                            if (shift_ff[7:1] == tccd_pkg::DEV_ADDR) begin
                                oe_ff <= 1'b1;
                                rd_mode_ff <= shift_ff[0];
                            end else begin
                                i2c_st_ff <= tccd_pkg::IS_IDLE;
                            end
                        end
                        tccd_pkg::IS_PTR: begin
                            ptr_ff <= shift_ff;
                            oe_ff <= 1'b1;
                            i2c_st_ff <= tccd_pkg::IS_WDATA;
                        end
                        tccd_pkg::IS_WDATA: begin
                            wr_stb_ff <= 1'b1;
                            wr_addr_ff <= ptr_ff;
                            wr_data_ff <= shift_ff;
                            ptr_ff <= ptr_ff + 8'h01;
                            oe_ff <= 1'b1;
                        end
                        default: begin
                            ptr_ff <= ptr_ff + 8'h01;
                            oe_ff <= 1'b0;
                        end
                    endcase
                end else if (i2c_st_ff == tccd_pkg::IS_RDATA) begin
                    oe_ff <= ~rd_byte_ff[3'h7 - bit_cnt_ff[2:0]];
                end
            end
        end
    end

    // writable registers; a hardware event wins over a same-cycle clear
    always_ff @(posedge CLK_IN) begin
        if (rst_all) begin
            switch_ff <= tccd_pkg::RST_SWITCH;
            txsel_ff <= tccd_pkg::RST_TXSEL;
            measure_ff <= tccd_pkg::RST_MEASURE;
            portctl_ff <= tccd_pkg::RST_PORTCTL;
            detctl_ff <= tccd_pkg::RST_DETCTL;
            events_ff <= 8'h00;
            ana_q_ff <= 6'h00;
        end else begin
            ana_q_ff <= ana_ff;
            if (wr_stb_ff) begin
                unique case (wr_addr_ff)
                    tccd_pkg::OFS_SWITCH: switch_ff <= wr_data_ff;
                    tccd_pkg::OFS_TXSEL: txsel_ff <= wr_data_ff;
                    tccd_pkg::OFS_MEASURE: measure_ff <= wr_data_ff;
                    tccd_pkg::OFS_PORTCTL: portctl_ff <= wr_data_ff;
                    tccd_pkg::OFS_DETCTL: detctl_ff <= wr_data_ff;
                    default: ;
                endcase
            end
            events_ff <= (events_ff & ~((wr_stb_ff && wr_addr_ff == tccd_pkg::OFS_EVENTS)
                ? wr_data_ff : 8'h00))
                | {4'h0, tog_done_ev, ana_ff[3] ^ ana_q_ff[3],
                   ana_ff[2] ^ ana_q_ff[2], |(ana_ff[1:0] ^ ana_q_ff[1:0])};
        end
    end

    // toggle timing: 10 us ticks, phase = (detctl[7:6]+1) * base ticks
    always_ff @(posedge CLK_IN) begin
        if (rst_all || tog_st_ff != tccd_pkg::TG_SRC && tog_st_ff != tccd_pkg::TG_SNK) begin
            tick_cnt_ff <= 8'h00;
            phase_cnt_ff <= 8'h00;
        end else if (tick_cnt_ff == 8'(tccd_pkg::TICK_CYC - 1)) begin
            tick_cnt_ff <= 8'h00;
            phase_cnt_ff <= (phase_cnt_ff == 8'({2'h0, detctl_ff[7:6]} + 4'h1)
                * tccd_pkg::PHASE_BASE_TICKS - 8'h01) ? 8'h00 : phase_cnt_ff + 8'h01;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 8'h01;
        end
    end

    logic phase_end;
    assign phase_end = tick_cnt_ff == 8'(tccd_pkg::TICK_CYC - 1)
        && phase_cnt_ff == 8'(({2'h0, detctl_ff[7:6]} + 4'h1) * tccd_pkg::PHASE_BASE_TICKS
        - 8'h01);
    assign tog_done_ev = tog_st_ff != tccd_pkg::TG_DONE && auto_en
        && ((tog_st_ff == tccd_pkg::TG_SRC && (term_ff[1:0] == tccd_pkg::TERM_RD
            || term_ff[3:2] == tccd_pkg::TERM_RD || term_ff == {2{tccd_pkg::TERM_RA}}))
        || (tog_st_ff == tccd_pkg::TG_SNK && (term_ff[1:0] == tccd_pkg::TERM_RP
            || term_ff[3:2] == tccd_pkg::TERM_RP)));

    always_ff @(posedge CLK_IN) begin
        if (rst_all) begin
            tog_st_ff <= tccd_pkg::TG_IDLE;
            tog_code_ff <= tccd_pkg::TOG_BUSY;
        end else if (!auto_en) begin
            tog_st_ff <= tccd_pkg::TG_IDLE;
            tog_code_ff <= tccd_pkg::TOG_BUSY;
        end else begin
            unique case (tog_st_ff)
                tccd_pkg::TG_IDLE: tog_st_ff <= (mode == tccd_pkg::MODE_SNK)
                    ? tccd_pkg::TG_SNK : tccd_pkg::TG_SRC;
                tccd_pkg::TG_SRC: begin
                    if (tog_done_ev) begin
                        tog_st_ff <= tccd_pkg::TG_DONE;
                        tog_code_ff <= (term_ff == {2{tccd_pkg::TERM_RA}}) ? tccd_pkg::TOG_AUDIO
                            : (term_ff[1:0] == tccd_pkg::TERM_RD) ? tccd_pkg::TOG_SRC_L1
                            : tccd_pkg::TOG_SRC_L2;
                    end else if (phase_end && mode == tccd_pkg::MODE_DRP) begin
                        tog_st_ff <= tccd_pkg::TG_SNK;
                    end
                end
                tccd_pkg::TG_SNK: begin
                    if (tog_done_ev) begin
                        tog_st_ff <= tccd_pkg::TG_DONE;
                        tog_code_ff <= (term_ff[1:0] == tccd_pkg::TERM_RP)
                            ? tccd_pkg::TOG_SNK_L1 : tccd_pkg::TOG_SNK_L2;
                    end else if (phase_end && mode == tccd_pkg::MODE_DRP) begin
                        tog_st_ff <= tccd_pkg::TG_SRC;
                    end
                end
                tccd_pkg::TG_DONE: tog_st_ff <= tccd_pkg::TG_DONE;
                default: tog_st_ff <= tccd_pkg::TG_IDLE;
            endcase
        end
    end

    // switch outputs: auto mode overrides pull and sense switches only
    always_ff @(posedge CLK_IN) begin
        if (rst_all) begin
            {SOURCE_PULLUP_LINE2_OUT, SOURCE_PULLUP_LINE1_OUT} <= 2'h0;
            {SINK_PULLDOWN_LINE2_OUT, SINK_PULLDOWN_LINE1_OUT} <= 2'h0;
            {SENSE_LINE2_OUT, SENSE_LINE1_OUT} <= 2'h0;
            {CABLE_SUPPLY_LINE2_OUT, CABLE_SUPPLY_LINE1_OUT} <= 2'h0;
            {TRANSMIT_ON_LINE2_OUT, TRANSMIT_ON_LINE1_OUT} <= 2'h0;
            DAC_THRESHOLD_CODE_OUT <= 6'h00;
            DAC_ON_SUPPLY_RAIL_OUT <= 1'b0;
            ADVERTISED_SOURCE_CURRENT_OUT <= 2'h0;
        end else begin
            if (auto_en) begin
                SOURCE_PULLUP_LINE1_OUT <= tog_st_ff == tccd_pkg::TG_SRC
                    || tog_st_ff == tccd_pkg::TG_DONE && !tog_code_ff[2];
                SOURCE_PULLUP_LINE2_OUT <= tog_st_ff == tccd_pkg::TG_SRC
                    || tog_st_ff == tccd_pkg::TG_DONE && !tog_code_ff[2];
                SINK_PULLDOWN_LINE1_OUT <= tog_st_ff == tccd_pkg::TG_SNK
                    || tog_st_ff == tccd_pkg::TG_DONE && tog_code_ff[2];
                SINK_PULLDOWN_LINE2_OUT <= tog_st_ff == tccd_pkg::TG_SNK
                    || tog_st_ff == tccd_pkg::TG_DONE && tog_code_ff[2];
                SENSE_LINE1_OUT <= tog_st_ff != tccd_pkg::TG_DONE || !tog_code_ff[1];
                SENSE_LINE2_OUT <= tog_st_ff != tccd_pkg::TG_DONE || tog_code_ff[1];
            end else begin
                SOURCE_PULLUP_LINE1_OUT <= switch_ff[tccd_pkg::SW_PU1];
                SOURCE_PULLUP_LINE2_OUT <= switch_ff[tccd_pkg::SW_PU2];
                SINK_PULLDOWN_LINE1_OUT <= switch_ff[tccd_pkg::SW_PDN1];
                SINK_PULLDOWN_LINE2_OUT <= switch_ff[tccd_pkg::SW_PDN2];
                SENSE_LINE1_OUT <= switch_ff[tccd_pkg::SW_MEAS1];
                SENSE_LINE2_OUT <= switch_ff[tccd_pkg::SW_MEAS2];
            end
            CABLE_SUPPLY_LINE1_OUT <= switch_ff[tccd_pkg::SW_VC1];
            CABLE_SUPPLY_LINE2_OUT <= switch_ff[tccd_pkg::SW_VC2];
            TRANSMIT_ON_LINE1_OUT <= txsel_ff[0];
            TRANSMIT_ON_LINE2_OUT <= txsel_ff[1];
            DAC_THRESHOLD_CODE_OUT <= measure_ff[5:0];
            DAC_ON_SUPPLY_RAIL_OUT <= measure_ff[tccd_pkg::MEAS_ON_SUPPLY];
            ADVERTISED_SOURCE_CURRENT_OUT <= portctl_ff[3:2];
        end
    end

    // open drain: data line only ever pulled low
    always_ff @(posedge CLK_IN) begin
        SDA_OUT <= 1'b0;
        SDA_OE_OUT <= rst_all ? 1'b0 : oe_ff;
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    a_soft_reset_regs: assert property ($rose(soft_rst_ff) |=> switch_ff == tccd_pkg::RST_SWITCH
        && detctl_ff == tccd_pkg::RST_DETCTL) else $error("soft reset left registers");
    a_proto_reset: assert property (soft_rst_ff |=> PROTOCOL_LOGIC_RESET_OUT)
        else $error("protocol reset missing");
    a_supply_switch: assert property (##1 !$past(rst_all) |-> CABLE_SUPPLY_LINE2_OUT
        == $past(switch_ff[tccd_pkg::SW_VC2])) else $error("cable supply mismatch");
    a_manual_pullup: assert property (!auto_en && !rst_all ##1 !rst_all |->
        SOURCE_PULLUP_LINE1_OUT == $past(switch_ff[tccd_pkg::SW_PU1]))
        else $error("manual pull-up mismatch");
    a_coarse_event: assert property (ana_ff[1:0] != ana_q_ff[1:0] && !rst_all
        |=> events_ff[tccd_pkg::EV_COARSE]) else $error("coarse event lost");
    a_comp_event: assert property (ana_ff[2] != ana_q_ff[2] && !rst_all
        |=> events_ff[tccd_pkg::EV_COMP]) else $error("compare event lost");
    a_supply_event: assert property (ana_ff[3] != ana_q_ff[3] && !rst_all
        |=> events_ff[tccd_pkg::EV_SUPPLY]) else $error("supply event lost");
    a_sink_only: assert property (tog_st_ff == tccd_pkg::TG_IDLE && auto_en && !rst_all
        && mode == tccd_pkg::MODE_SNK |=> tog_st_ff == tccd_pkg::TG_SNK)
        else $error("sink-only mode began as source");
    a_done_holds: assert property (tog_st_ff == tccd_pkg::TG_DONE && auto_en && !rst_all
        |=> $stable(tog_code_ff) && tog_code_ff != tccd_pkg::TOG_BUSY)
        else $error("toggle outcome changed");
    a_done_event: assert property (tog_done_ev && !rst_all |=> events_ff[tccd_pkg::EV_TOGDONE]
        && tog_st_ff == tccd_pkg::TG_DONE) else $error("toggle done not flagged");
    c_drp_swap: cover property (tog_st_ff == tccd_pkg::TG_SRC ##1 tog_st_ff == tccd_pkg::TG_SNK);
    c_src_attach: cover property (tog_code_ff == tccd_pkg::TOG_SRC_L2);
    c_i2c_write: cover property (wr_stb_ff);
endmodule : tccd_top
`default_nettype wire

// [tccd_pkg.sv]
// package: register map, field positions and timing constants of the cc detection block
package tccd_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h22;
    localparam logic [7:0] OFS_SWITCH = 8'h02;
    localparam logic [7:0] OFS_TXSEL = 8'h03;
    localparam logic [7:0] OFS_MEASURE = 8'h04;
    localparam logic [7:0] OFS_PORTCTL = 8'h06;
    localparam logic [7:0] OFS_DETCTL = 8'h08;
    localparam logic [7:0] OFS_RESET = 8'h0c;
    localparam logic [7:0] OFS_TOGSTAT = 8'h3d;
    localparam logic [7:0] OFS_LVLSTAT = 8'h40;
    localparam logic [7:0] OFS_EVENTS = 8'h42;
    localparam logic [7:0] RST_SWITCH = 8'h03;
    localparam logic [7:0] RST_TXSEL = 8'h00;
    localparam logic [7:0] RST_MEASURE = 8'h31;
    localparam logic [7:0] RST_PORTCTL = 8'h04;
    localparam logic [7:0] RST_DETCTL = 8'h04;
    localparam int SW_PDN1 = 0;
    localparam int SW_PDN2 = 1;
    localparam int SW_MEAS1 = 2;
    localparam int SW_MEAS2 = 3;
    localparam int SW_VC1 = 4;
    localparam int SW_VC2 = 5;
    localparam int SW_PU1 = 6;
    localparam int SW_PU2 = 7;
    localparam int MEAS_ON_SUPPLY = 6;
    localparam int RST_CHIP = 0;
    localparam int RST_PROTO = 1;
    localparam int EV_COARSE = 0;
    localparam int EV_COMP = 1;
    localparam int EV_SUPPLY = 2;
    localparam int EV_TOGDONE = 3;
    localparam logic [1:0] MODE_DRP = 2'b01;
    localparam logic [1:0] MODE_SNK = 2'b10;
    localparam logic [1:0] MODE_SRC = 2'b11;
    localparam logic [1:0] TERM_OPEN = 2'h0;
    localparam logic [1:0] TERM_RD = 2'h1;
    localparam logic [1:0] TERM_RA = 2'h2;
    localparam logic [1:0] TERM_RP = 2'h3;
    localparam logic [2:0] TOG_BUSY = 3'h0;
    localparam logic [2:0] TOG_SRC_L1 = 3'h1;
    localparam logic [2:0] TOG_SRC_L2 = 3'h2;
    localparam logic [2:0] TOG_SNK_L1 = 3'h5;
    localparam logic [2:0] TOG_SNK_L2 = 3'h6;
    localparam logic [2:0] TOG_AUDIO = 3'h7;
    localparam int CLK_NS = 50;
    localparam int TICK_NS = 10000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] PHASE_BASE_TICKS = 8'h05;
    typedef enum logic [3:0] {
        TG_IDLE = 4'b0001,
        TG_SRC = 4'b0010,
        TG_SNK = 4'b0100,
        TG_DONE = 4'b1000
    } tccd_tog_t;
    typedef enum logic [4:0] {
        IS_IDLE = 5'b00001,
        IS_DEV = 5'b00010,
        IS_PTR = 5'b00100,
        IS_WDATA = 5'b01000,
        IS_RDATA = 5'b10000
    } tccd_i2c_t;
endpackage : tccd_pkg

// [tccd_cc_partner.sv]
// remote cc port partner model facing the switch matrix
`timescale 1ns/1ps
`default_nettype none
module tccd_cc_partner (
    input wire logic [1:0] kind_in,
    input wire logic pd1_in,
    input wire logic pu1_in,
    output logic [1:0] t1_out,
    output logic [1:0] t2_out,
    output logic [1:0] lvl_out,
    output logic cmp_out,
    output logic vbus_out
);
    // kind 1 source, 2 sink, 3 audio accessory, 0 nothing on the plug
    assign t1_out = kind_in == 2'h1 ? 2'h3 : kind_in == 2'h2 ? 2'h1 : {kind_in[1], 1'b0};
    assign t2_out = kind_in == 2'h3 ? 2'h2 : 2'h0;
    // a source only drives the supply rail once our pull-down is seen
    assign vbus_out = kind_in == 2'h1 && pd1_in;
    assign lvl_out = kind_in == 2'h1 ? (pd1_in ? 2'h2 : 2'h3) : 2'h0;
    assign cmp_out = !(kind_in == 2'h2 && pu1_in);
endmodule : tccd_cc_partner
`default_nettype wire

// [typec_cc_detection_control_tb.sv]
// testbench of the cc detection control block
`timescale 1ns/1ps
`default_nettype none
module typec_cc_detection_control_tb;
    logic clk = 1'b0, rst_n = 1'b0, scl = 1'b1, sda_m = 1'b1, pr_seen = 1'b0;
    logic [1:0] kind = 2'h0;
    wire sda_oe, pr, cmp, vb, dsup, sda_o;
    wire [1:0] lvl, t1, t2, cur, tx;
    wire [5:0] code;
    wire [7:0] sw;
    wire sda = sda_m & ~sda_oe;
    int num_errors = 0, n_compared = 0;
    logic [15:0] rows [10] = '{16'h02a5, 16'h025a, 16'h0301, 16'h0302, 16'h0474,
        16'h0426, 16'h043e, 16'h0608, 16'h060c, 16'h0604};
    logic [15:0] rst_rows [6] = '{16'h0203, 16'h0300, 16'h0431, 16'h0604, 16'h0804, 16'h0500};
    tccd_top tccd_top_i (.CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
        .SDA_OE_OUT(sda_oe), .COARSE_LEVEL_IN(lvl), .DAC_COMPARE_IN(cmp), .SUPPLY_VALID_IN(vb),
        .LINE1_TERM_IN(t1), .LINE2_TERM_IN(t2), .CABLE_SUPPLY_LINE1_OUT(sw[4]),
        .CABLE_SUPPLY_LINE2_OUT(sw[5]), .SENSE_LINE1_OUT(sw[2]), .SENSE_LINE2_OUT(sw[3]),
        .TRANSMIT_ON_LINE1_OUT(tx[0]), .TRANSMIT_ON_LINE2_OUT(tx[1]),
        .SOURCE_PULLUP_LINE1_OUT(sw[6]), .SOURCE_PULLUP_LINE2_OUT(sw[7]),
        .SINK_PULLDOWN_LINE1_OUT(sw[0]), .SINK_PULLDOWN_LINE2_OUT(sw[1]),
        .DAC_THRESHOLD_CODE_OUT(code), .DAC_ON_SUPPLY_RAIL_OUT(dsup),
        .ADVERTISED_SOURCE_CURRENT_OUT(cur), .PROTOCOL_LOGIC_RESET_OUT(pr));
    tccd_cc_partner tccd_cc_partner_i (.kind_in(kind), .pd1_in(sw[0]), .pu1_in(sw[6]),
        .t1_out(t1), .t2_out(t2), .lvl_out(lvl), .cmp_out(cmp), .vbus_out(vb));
    initial forever #25 clk = ~clk;
    // the reset pulse lasts one or two cycles, so latch it
    always @(posedge clk) if (pr === 1'b1) pr_seen <= 1'b1;
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : tk
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // scl low spans 10 cycles, well over the slave's sampling lag
    task automatic bitx(input logic b, output logic r);
        sda_m = b;
        tk(5);
        scl = 1'b1;
        tk(10);
        r = sda;
        scl = 1'b0;
        tk(5);
    endtask : bitx
    task automatic st(input logic stop);
        sda_m = stop ? 1'b0 : 1'b1;
        tk(5);
        scl = 1'b1;
        tk(10);
        sda_m = stop;
        tk(10);
        if (!stop) scl = 1'b0;
        tk(5);
    endtask : st
    // ninth bit always released: single-byte reads end with nack
    task automatic xb(input logic [7:0] w, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
        bitx(1'b1, a);
    endtask : xb
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        logic [7:0] r;
        st(1'b0);
        xb({tccd_pkg::DEV_ADDR, 1'b0}, r);
        xb(o, r);
        xb(d, r);
        st(1'b1);
    endtask : wr
    task automatic rc(input string nm, input logic [7:0] o, m, e);
        logic [7:0] d;
        st(1'b0);
        xb({tccd_pkg::DEV_ADDR, 1'b0}, d);
        xb(o, d);
        st(1'b0);
        xb({tccd_pkg::DEV_ADDR, 1'b1}, d);
        xb(8'hff, d);
        st(1'b1);
        chk(nm, d & m, e);
    endtask : rc
    task automatic defaults();
        foreach (rst_rows[i]) rc("default", rst_rows[i][15:8], 8'hff, rst_rows[i][7:0]);
    endtask : defaults
    function automatic logic [7:0] vw(input logic [7:0] o);
        case (o)
            8'h02: return sw;
            8'h03: return {6'h00, tx};
            8'h04: return {1'b0, dsup, code};
            default: return {4'h0, cur, 2'h0};
        endcase
    endfunction : vw
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
    initial begin
        tk(6);
        rst_n = 1'b1;
        tk(4);
        chk("pulldowns", sw, 8'h03);
        chk("sda drive level", {7'h00, sda_o}, 8'h00);
        defaults();
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i][15:8], rows[i][7:0]);
            rc("readback", rows[i][15:8], 8'hff, rows[i][7:0]);
            chk("pins", vw(rows[i][15:8]), rows[i][7:0]);
        end
        $display("test register rows done");
        wr(8'h42, 8'h0f);
        wr(8'h02, 8'h05);
        kind = 2'h1;
        rc("sink status", 8'h40, 8'ha3, 8'ha2);
        rc("sink events", 8'h42, 8'h05, 8'h05);
        wr(8'h42, 8'h0f);
        kind = 2'h0;
        rc("detach", 8'h40, 8'h80, 8'h00);
        wr(8'h02, 8'h44);
        wr(8'h04, 8'h26);
        wr(8'h42, 8'h0f);
        kind = 2'h2;
        rc("sink seen", 8'h40, 8'h20, 8'h00);
        rc("cmp event", 8'h42, 8'h02, 8'h02);
        $display("test manual detection done");
        kind = 2'h1;
        wr(8'h06, 8'h04);
        wr(8'h08, 8'h05);
        tk(3000);
        rc("outcome", 8'h3d, 8'h38, 8'h28);
        rc("done event", 8'h42, 8'h08, 8'h08);
        chk("auto pulldown", {7'h00, sw[0]}, 8'h01);
        $display("test auto sink done");
        wr(8'h0c, 8'h02);
        chk("proto reset", {7'h00, pr_seen}, 8'h01);
        wr(8'h0c, 8'h01);
        tk(10);
        defaults();
        rc("outcome cleared", 8'h3d, 8'h38, 8'h00);
        $display("test resets done");
        give_verdict();
    end
endmodule : typec_cc_detection_control_tb
`default_nettype wire
